// ===== logic/adc_cal_regs.vh
/*
  Register offsets, field positions, reset values and codes for the
  calibration, system-control and pin register slice.
  Assumes it is included by bare name from the design file.
*/
`ifndef ADC_CAL_REGS_VH
`define ADC_CAL_REGS_VH

`define SYSCTL_IDX        8'h09
`define OFS_LOW_IDX       8'h0a
`define OFS_MID_IDX       8'h0b
`define OFS_HIGH_IDX      8'h0c
`define FS_LOW_IDX        8'h0d
`define FS_MID_IDX        8'h0e
`define FS_HIGH_IDX       8'h0f
`define PIN_DL_IDX        8'h10
`define PIN_FUNC_IDX      8'h11
`define SYSCTL_RST        8'h10
`define OFS_RST           8'h00
`define FS_LOW_RST        8'h00
`define FS_MID_RST        8'h00
`define FS_HIGH_RST       8'h40
`define PIN_DL_RST        8'h00
`define PIN_FUNC_RST      8'h00
`define BIT_STAT          0
`define BIT_CRC           1
`define BIT_TMO           2
`define MON_LSB           5
`define MON_MSB           7
`define MON_MID           3'h1
`define MON_TEMP          3'h2
`define MON_AVDD          3'h3
`define MON_DVDD          3'h4
`define GAIN_UNITY        3'h0
`define TEMP_GAIN_MAX     3'h2
`define CRC_POLY          8'h07

`endif

// ===== logic/adc_cal_slice.v
/*
  APB register slice of a sensor converter: system-control low bits and
  monitor select, offset and full-scale trim values, pin direction/level
  and pin function select, with the output framing and CRC engine that
  these bits steer.
  Assumes a 25 MHz clock, an APB master on the same clock, and that the
  converter core presents each result with a one-cycle strobe and takes
  framed bytes one at a time through a valid/ready pair.
  Limitations: a result that arrives while a frame is still being sent
  is dropped, and the serial timeout itself lives elsewhere; this slice
  only presents its enable. The gain limit while measuring temperature
  is the host's duty; the slice only flags a breach of it.
  Pin inputs are asynchronous and are filtered before use.
*/
`include "adc_cal_regs.vh"
`default_nettype none
module adc_cal_slice (
  input  wire        mclk_i,
  input  wire        resetn_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  input  wire [2:0]  gain_req_i,
  input  wire        result_vld_i,
  input  wire [23:0] result_i,
  input  wire [7:0]  status_i,
  input  wire        frame_rdy_i,
  output reg         frame_vld_o,
  output reg  [7:0]  frame_byte_o,
  output reg         frame_last_o,
  output reg         timeout_en_o,
  output reg  [2:0]  gain_eff_o,
  output reg         inputs_open_o,
  output reg         temp_gain_err_o,
  output reg  [23:0] offset_trim_value_o,
  output reg  [23:0] fullscale_trim_value_o,
  input  wire [3:0]  pin_in_i,
  output reg  [3:0]  pin_out_o,
  output reg  [3:0]  pin_oen_o,
  output reg  [3:0]  analog_inputs_o
);

  // Framer states, one-hot.
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_STAT = 4'b0010;
  localparam [3:0] ST_DATA = 4'b0100;
  localparam [3:0] ST_CRC  = 4'b1000;

  // Stored register bytes; the pin byte keeps the written levels.
  reg [7:0]  sysctl_reg;
  reg [7:0]  ofs_low_reg;
  reg [7:0]  ofs_mid_reg;
  reg [7:0]  ofs_high_reg;
  reg [7:0]  fs_low_reg;
  reg [7:0]  fs_mid_reg;
  reg [7:0]  fs_high_reg;
  reg [7:0]  pin_dl_reg;
  reg [3:0]  pin_function_select_reg;
  // Three-stage pin sampler and the filtered level it settles on.
  reg [3:0]  pin_s1_reg;
  reg [3:0]  pin_s2_reg;
  reg [3:0]  pin_s3_reg;
  reg [3:0]  pin_sampled_reg;
  // Framer state and per-frame copies of the result and options.
  reg [3:0]  state_reg;
  reg [3:0]  state_next;
  reg [23:0] res_reg;
  reg [7:0]  stat_reg;
  reg [1:0]  cnt_reg;
  reg [7:0]  crc_reg;
  reg        send_stat_reg;
  reg        send_crc_reg;
  reg [31:0] rdata_next;
  reg [7:0]  cur_byte;

  // Address decode: word index from the byte address; only aligned
  // words 09h to 11h answer, everything else gets an error response.
  wire [2:0] monitor_select = sysctl_reg[`MON_MSB:`MON_LSB];
  wire [9:0] widx           = paddr_i[11:2];
  wire       acc            = psel_i & penable_i;
  wire       wr             = acc & pwrite_i & pready_o;
  wire       aligned        = (paddr_i[1:0] == 2'b00);
  wire       hit            = aligned & (widx[9:8] == 2'b00) &
                              (widx[7:0] >= `SYSCTL_IDX) &
                              (widx[7:0] <= `PIN_FUNC_IDX);
  wire       take           = frame_vld_o & frame_rdy_i;
  wire       supply_mon     = (monitor_select == `MON_AVDD) |
                              (monitor_select == `MON_DVDD);

  // Byte-serial CRC-8, shared by the status and the data bytes.
  // Polynomial and start value are ours; the host must use the same.
  function [7:0] crc8;
    input [7:0] c;
    input [7:0] d;
    integer i;
    reg [7:0] x;
    begin
      x = c ^ d;
      for (i = 0; i < 8; i = i + 1) begin
        x = x[7] ? ((x << 1) ^ `CRC_POLY) : (x << 1);
      end
      crc8 = x;
    end
  endfunction

  // Register writes, taken only in the access cycle that completes.
  // The pin function byte keeps only its four live bits; the upper
  // bits read back as zero.
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sysctl_reg              <= `SYSCTL_RST;
      ofs_low_reg             <= `OFS_RST;
      ofs_mid_reg             <= `OFS_RST;
      ofs_high_reg            <= `OFS_RST;
      fs_low_reg              <= `FS_LOW_RST;
      fs_mid_reg              <= `FS_MID_RST;
      fs_high_reg             <= `FS_HIGH_RST;
      pin_dl_reg              <= `PIN_DL_RST;
      pin_function_select_reg <= 4'h0;
    end else if (wr && hit) begin
      case (widx[7:0])
        `SYSCTL_IDX:   sysctl_reg   <= pwdata_i[7:0];
        `OFS_LOW_IDX:  ofs_low_reg  <= pwdata_i[7:0];
        `OFS_MID_IDX:  ofs_mid_reg  <= pwdata_i[7:0];
        `OFS_HIGH_IDX: ofs_high_reg <= pwdata_i[7:0];
        `FS_LOW_IDX:   fs_low_reg   <= pwdata_i[7:0];
        `FS_MID_IDX:   fs_mid_reg   <= pwdata_i[7:0];
        `FS_HIGH_IDX:  fs_high_reg  <= pwdata_i[7:0];
        `PIN_DL_IDX:   pin_dl_reg   <= pwdata_i[7:0];
        `PIN_FUNC_IDX: pin_function_select_reg <= pwdata_i[3:0];
        default:       sysctl_reg   <= sysctl_reg;
      endcase
    end
  end

  // Read mux; input pins show the sampled level, outputs the written one.
  // Direction 1 with function 1 selects the sampled level of a pin.
  // Unmapped reads return zero so a stray read never leaks state.
  always @* begin
    rdata_next = 32'h0000_0000;
    case (widx[7:0])
      `SYSCTL_IDX:   rdata_next[7:0] = sysctl_reg;
      `OFS_LOW_IDX:  rdata_next[7:0] = ofs_low_reg;
      `OFS_MID_IDX:  rdata_next[7:0] = ofs_mid_reg;
      `OFS_HIGH_IDX: rdata_next[7:0] = ofs_high_reg;
      `FS_LOW_IDX:   rdata_next[7:0] = fs_low_reg;
      `FS_MID_IDX:   rdata_next[7:0] = fs_mid_reg;
      `FS_HIGH_IDX:  rdata_next[7:0] = fs_high_reg;
      `PIN_DL_IDX:   rdata_next[7:0] = {pin_dl_reg[7:4],
                       (pin_dl_reg[7:4] & pin_function_select_reg &
                        pin_sampled_reg) |
                       (~(pin_dl_reg[7:4] & pin_function_select_reg) &
                        pin_dl_reg[3:0])};
      `PIN_FUNC_IDX: rdata_next[3:0] = pin_function_select_reg;
      default:       rdata_next = 32'h0000_0000;
    endcase
    if (!hit) begin
      rdata_next = 32'h0000_0000;
    end
  end

  // APB answer: one wait state, so pready rises in the second access
  // cycle; registered data keeps every bus output straight from a flop.
  // The wait state buys a full cycle for the read mux to settle before
  // the data is captured.
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prdata_o  <= 32'h0000_0000;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else if (acc && !pready_o) begin
      prdata_o  <= rdata_next;
      pready_o  <= 1'b1;
      pslverr_o <= ~hit;
    end else begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  // Pin inputs cross from outside: three flops, accepted when two agree.
  // A glitch shorter than one cycle never reaches the filtered level.
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_s1_reg      <= 4'h0;
      pin_s2_reg      <= 4'h0;
      pin_s3_reg      <= 4'h0;
      pin_sampled_reg <= 4'h0;
    end else begin
      pin_s1_reg      <= pin_in_i;
      pin_s2_reg      <= pin_s1_reg;
      pin_s3_reg      <= pin_s2_reg;
      pin_sampled_reg <= (pin_s2_reg & pin_s3_reg) |
                         (pin_sampled_reg & (pin_s2_reg | pin_s3_reg));
    end
  end

  // Control outputs, registered so each is a flop output.
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      timeout_en_o           <= 1'b0;
      gain_eff_o             <= `GAIN_UNITY;
      inputs_open_o          <= 1'b0;
      temp_gain_err_o        <= 1'b0;
      offset_trim_value_o    <= 24'h00_0000;
      fullscale_trim_value_o <= 24'h40_0000;
      pin_out_o              <= 4'h0;
      pin_oen_o              <= 4'hf;
      analog_inputs_o        <= 4'hf;
    end else begin
      timeout_en_o <= sysctl_reg[`BIT_TMO];
      gain_eff_o   <= supply_mon ? `GAIN_UNITY : gain_req_i;
      // Mid-supply also opens the switches, as it shorts the amplifier.
      inputs_open_o <= (monitor_select >= `MON_MID) &&
                       (monitor_select <= `MON_DVDD);
      // Flags a host that breaks the temperature gain limit; gain is
      // passed through unchanged since the host owns this choice.
      temp_gain_err_o <= (monitor_select == `MON_TEMP) &&
                         (gain_req_i > `TEMP_GAIN_MAX);
      // Bytes are written one at a time, so a trim is briefly mixed.
      offset_trim_value_o    <= {ofs_high_reg, ofs_mid_reg, ofs_low_reg};
      fullscale_trim_value_o <= {fs_high_reg, fs_mid_reg, fs_low_reg};
      pin_out_o <= pin_dl_reg[3:0];
      // Low enable drives; only digital output pins drive.
      // An input or analog pin is released so it never fights the pad.
      pin_oen_o <= ~(pin_function_select_reg &
                     ~pin_dl_reg[7:4]);
      analog_inputs_o <= ~pin_function_select_reg;
    end
  end

  // Byte currently on offer, chosen by state and data byte count.
  // Only three data counts occur, so count 3 falls to the low byte.
  always @* begin
    cur_byte = stat_reg;
    if (state_reg == ST_DATA) begin
      case (cnt_reg)
        2'd0:    cur_byte = res_reg[23:16];
        2'd1:    cur_byte = res_reg[15:8];
        default: cur_byte = res_reg[7:0];
      endcase
    end else if (state_reg == ST_CRC) begin
      cur_byte = crc_reg;
    end
  end

  // Framer sequencing; a result arriving mid-frame is dropped.
  // Options are sampled from the live register at the result strobe.
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (result_vld_i) begin
          state_next = sysctl_reg[`BIT_STAT] ? ST_STAT : ST_DATA;
        end
      end
      ST_STAT: if (take) state_next = ST_DATA;
      ST_DATA: begin
        if (take && cnt_reg == 2'd2) begin
          state_next = send_crc_reg ? ST_CRC : ST_IDLE;
        end
      end
      ST_CRC:  if (take) state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  // Framer datapath; options are latched per frame so a write lands on
  // the next result, never splitting one. The CRC restarts at zero for
  // every frame.
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg     <= ST_IDLE;
      res_reg       <= 24'h00_0000;
      stat_reg      <= 8'h00;
      cnt_reg       <= 2'd0;
      crc_reg       <= 8'h00;
      send_stat_reg <= 1'b0;
      send_crc_reg  <= 1'b0;
      frame_vld_o   <= 1'b0;
      frame_byte_o  <= 8'h00;
      frame_last_o  <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_IDLE && result_vld_i) begin
        res_reg       <= result_i;
        stat_reg      <= status_i;
        cnt_reg       <= 2'd0;
        crc_reg       <= 8'h00;
        send_stat_reg <= sysctl_reg[`BIT_STAT];
        send_crc_reg  <= sysctl_reg[`BIT_CRC];
      end else if (take) begin
        crc_reg <= crc8(crc_reg, frame_byte_o);
        if (state_reg == ST_DATA) begin
          cnt_reg <= cnt_reg + 2'd1;
        end
      end
      if (state_next == ST_IDLE) begin
        frame_vld_o  <= 1'b0;
        frame_last_o <= 1'b0;
      end else if (!frame_vld_o || take) begin
        frame_vld_o <= 1'b1;
        if (state_next != state_reg || take) begin
          frame_vld_o <= 1'b0;
        end
      end
      // Load a fresh byte once the last one has gone and the state has
      // settled; the gap cycle keeps valid off a stale byte.
      if (!frame_vld_o && state_reg != ST_IDLE &&
          state_next == state_reg) begin
        frame_vld_o  <= 1'b1;
        frame_byte_o <= cur_byte;
        frame_last_o <= (state_reg == ST_CRC) ||
                        (state_reg == ST_DATA && cnt_reg == 2'd2 &&
                         !send_crc_reg);
      end
    end
  end

endmodule
`default_nettype wire

// ===== test/adc_cal_checker_asserts.sv
/* Checker for the register slice: APB timing, control outputs, framing.
   Assumes it is bound to the slice and sees only the slice's ports. */
`default_nettype none
module adc_cal_checker (
  input wire logic        mclk_i,
  input wire logic        resetn_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic [2:0]  gain_req_i,
  input wire logic        frame_rdy_i,
  input wire logic        frame_vld_o,
  input wire logic [7:0]  frame_byte_o,
  input wire logic        frame_last_o,
  input wire logic        timeout_en_o,
  input wire logic [2:0]  gain_eff_o,
  input wire logic        inputs_open_o,
  input wire logic        temp_gain_err_o,
  input wire logic [23:0] offset_trim_value_o,
  input wire logic [23:0] fullscale_trim_value_o,
  input wire logic [3:0]  pin_oen_o,
  input wire logic [3:0]  analog_inputs_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] mon_q;
  logic       up_q;
  wire        map_ok = paddr_i[1:0] == 2'h0 && paddr_i >= 12'h024
                       && paddr_i <= 12'h044;
  wire        ctl_wr = psel_i && penable_i && pready_o && pwrite_i
                       && paddr_i == 12'h024;
  // Shadow of the monitor field; up_q masks the first edge after reset,
  // where the registered outputs still show their reset values.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mon_q <= 3'h0;
      up_q  <= 1'b0;
    end else begin
      up_q <= 1'b1;
      if (ctl_wr)
        mon_q <= pwdata_i[7:5];
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  a_ready_wait: assert property ($rose(penable_i) && psel_i |->
    !pready_o ##1 pready_o) else $error("pready not after one wait");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  a_err_map: assert property (pready_o |-> pslverr_o == !map_ok)
    else $error("error response on wrong address");
  a_timeout_follow: assert property (ctl_wr |-> ##2
    timeout_en_o == $past(pwdata_i[2], 2)) else $error("timeout enable");
  a_gain_select: assert property (up_q && $stable(mon_q)
    && $stable(gain_req_i) |-> gain_eff_o == ((mon_q == 3'h3
    || mon_q == 3'h4) ? 3'h0 : gain_req_i)) else $error("gain wrong");
  a_inputs_open: assert property (up_q && $stable(mon_q) |->
    inputs_open_o == (mon_q >= 3'h1 && mon_q <= 3'h4))
    else $error("input switches wrong");
  a_temp_gain: assert property (up_q && $stable(mon_q)
    && $stable(gain_req_i) |-> temp_gain_err_o == (mon_q == 3'h2
    && gain_req_i > 3'h2)) else $error("temperature gain flag wrong");
  a_trim_reset: assert property ($rose(resetn_i) |->
    offset_trim_value_o == 24'h0 && fullscale_trim_value_o == 24'h40_0000)
    else $error("trim reset value wrong");
  a_frame_hold: assert property (frame_vld_o && !frame_rdy_i |=>
    frame_vld_o && $stable(frame_byte_o) && $stable(frame_last_o))
    else $error("frame byte not held");
  a_pin_analog: assert property ((pin_oen_o | ~analog_inputs_o)
    == 4'hf) else $error("analog pin driven");
endmodule
bind adc_cal_slice adc_cal_checker chk_u (.*);
`default_nettype wire

// ===== test/frame_sink.sv
/* Sink model for the framed result bytes, standing for the host side.
   Assumes the slice offers bytes on a valid/ready pair on mclk_i. */
`default_nettype none
module frame_sink (
  input  wire logic       mclk_i,
  input  wire logic       resetn_i,
  input  wire logic       vld_i,
  input  wire logic [7:0] byte_i,
  input  wire logic       last_i,
  input  wire logic       stall_i,
  output var  logic       rdy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] got[$];
  // Ready is redrawn each cycle while stalling, so the slice must hold a
  // byte through any run of refusals.
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdy_o <= 1'b0;
    end else begin
      if (vld_i && rdy_o)
        got.push_back({last_i, byte_i});
      rdy_o <= stall_i ? 1'($urandom_range(1)) : 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== test/tb.sv
/* Self-checking bench for the register slice, with a frame sink.
   Assumes the slice, its header, the sink and the bound checker. */
`include "adc_cal_regs.vh"
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got %h want %h", $time, g, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i = 0, resetn_i = 0, psel_i = 0, penable_i = 0;
  logic        pwrite_i = 0, result_vld_i = 0, stall_i = 0, er;
  logic        pready_o, pslverr_o, frame_rdy_i, frame_vld_o, frame_last_o;
  logic        timeout_en_o, inputs_open_o, temp_gain_err_o;
  logic [2:0]  gain_req_i = 0, gain_eff_o, g;
  logic [3:0]  pin_in_i = 0, pin_out_o, pin_oen_o, analog_inputs_o;
  logic [7:0]  status_i = 0, frame_byte_o, c, exp[$];
  logic [7:0]  mdl[9] = '{8'h10, 0, 0, 0, 0, 0, 8'h40, 0, 0};
  logic [11:0] paddr_i = 0;
  logic [23:0] result_i = 0, offset_trim_value_o, fullscale_trim_value_o;
  logic [31:0] pwdata_i = 0, prdata_o, rd, d;
  int          error_cnt = 0, n_tests = 0, k, n;
  adc_cal_slice dut_u (.*);
  frame_sink sink_u (.mclk_i, .resetn_i, .vld_i(frame_vld_o),
    .byte_i(frame_byte_o), .last_i(frame_last_o), .stall_i,
    .rdy_o(frame_rdy_i));
  // Free-running 25 MHz clock.
  initial begin
    forever #20 mclk_i = ~mclk_i;
  end
  // Watchdog: far beyond the few hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge mclk_i);
    error_cnt++;
    finish_test();
  end
  function automatic logic [7:0] crc8(logic [7:0] s, logic [7:0] b);
    s = s ^ b;
    for (int i = 0; i < 8; i++)
      s = s[7] ? {s[6:0], 1'b0} ^ `CRC_POLY : {s[6:0], 1'b0};
    return s;
  endfunction
  // One APB transfer; holds the request until pready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] v);
    int t;
    t = 0;
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= v;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do @(posedge mclk_i); while (pready_o !== 1'b1 && ++t < 20);
    if (t >= 20) error_cnt++;
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Main sequence: reset values, random access, refusals, monitor codes,
  // framing in all four formats, then the pins.
  initial begin
    void'($urandom(32'he411));
    repeat (20) @(posedge mclk_i);
    resetn_i <= 1'b1;
    `CHK(timeout_en_o, 1'b0)
    for (k = 0; k < 9; k++) begin
      apb(1'b0, 12'(k * 4 + 36), 0);
      `CHK(rd, {24'h0, mdl[k]})
    end
    $display("reset values done");
    for (int i = 0; i < 30; i++) begin
      k = 1 + $urandom_range(6);
      d = $urandom;
      apb(1'b1, 12'(k * 4 + 36), d);
      mdl[k] = d[7:0];
      apb(1'b0, 12'(k * 4 + 36), 0);
      `CHK(rd, {24'h0, mdl[k]})
    end
    apb(1'b1, 12'h029, 32'hffff_ffff);
    `CHK(er, 1'b1)
    apb(1'b0, 12'h028, 0);
    `CHK(rd, {24'h0, mdl[1]})
    apb(1'b0, 12'h048, 0);
    `CHK({er, rd}, 33'h1_0000_0000)
    `CHK(offset_trim_value_o, {mdl[3], mdl[2], mdl[1]})
    `CHK(fullscale_trim_value_o, {mdl[6], mdl[5], mdl[4]})
    $display("register access done");
    for (int m = 0; m < 8; m++) begin
      g = (m == 2) ? 3'($urandom_range(2)) : 3'($urandom_range(7));
      gain_req_i <= g;
      apb(1'b1, 12'h024, {24'h0, 3'(m), 5'h04});
      repeat (2) @(posedge mclk_i);
      `CHK(timeout_en_o, 1'b1)
      `CHK(gain_eff_o, (m == 3 || m == 4) ? 3'h0 : g)
      `CHK(inputs_open_o, (m >= 1 && m <= 4))
      `CHK(temp_gain_err_o, 1'b0)
    end
    $display("monitor codes done");
    for (int m = 0; m < 4; m++) begin
      stall_i <= m[0];
      apb(1'b1, 12'h024, 32'(m));
      d = $urandom;
      exp = {d[23:16], d[15:8], d[7:0]};
      if (m[0]) exp.push_front(d[31:24]);
      c = 8'h00;
      foreach (exp[i]) c = crc8(c, exp[i]);
      if (m[1]) exp.push_back(c);
      sink_u.got.delete();
      result_vld_i <= 1'b1;
      result_i <= d[23:0];
      status_i <= d[31:24];
      @(posedge mclk_i);
      result_vld_i <= 1'b0;
      for (n = 0; sink_u.got.size() < exp.size() && n < 200; n++)
        @(posedge mclk_i);
      repeat (8) @(posedge mclk_i);
      `CHK(sink_u.got.size(), exp.size())
      foreach (exp[i])
        `CHK(sink_u.got[i], {i == exp.size() - 1, exp[i]})
    end
    $display("framing done");
    d = $urandom;
    pin_in_i <= d[11:8];
    apb(1'b1, 12'h044, 32'h0000_000f);
    apb(1'b1, 12'h040, {24'h0, 4'ha, d[3:0]});
    repeat (4) @(posedge mclk_i);
    `CHK(pin_oen_o, 4'ha)
    `CHK(pin_out_o & 4'h5, d[3:0] & 4'h5)
    apb(1'b0, 12'h040, 0);
    `CHK(rd[7:0], {4'ha, (d[11:8] & 4'ha) | (d[3:0] & 4'h5)})
    apb(1'b1, 12'h044, 32'h0000_0007);
    apb(1'b1, 12'h040, 0);
    repeat (2) @(posedge mclk_i);
    `CHK({analog_inputs_o, pin_oen_o}, 8'h88)
    $display("pins done");
    finish_test();
  end
endmodule
`default_nettype wire
